// ---- pkg/adc_cmd_pkg.sv ----
// constants, codes and field positions of the serial command and configuration block
// What this block does
// - short command acts on fourth falling edge
// - command 1110b plus twelve bits, sixteenth edge
// - all ones on 1111b or any reset
// - command input and data output same frame
// - all commands but config read output result
// - 1100b returns four result MSBs, config word
// - D11 selects manual or automatic channel sequencing
// - D10 selects serial clock half or oscillator
// - D9 selects auto restart or convert_start_n
// - D8 selects 21 or 42 conversion clocks
// - D7 sets status pin polarity
// - D6 selects ready interrupt or conversion done
// - D5 zero turns status pin into input
// - D4 zero enables auto doze unless D9, D8 zero
// - D3, D2 power-downs; wake-up sets both
// - D1 appends channel tag bits
// - writing D0 zero resets, bit returns one
// - result captured at done, shown at frame
// - early frame gets previous, late gets current
// - result MSB first, tag, then zeros
// - data output driven only inside frame
// - polarity one phase zero, falling edge sampling
// - codes 0-7 channel, Bh wake, Dh read
package adc_cmd_pkg;

	// ---------------------------------------------
	// widths
	// ---------------------------------------------
	localparam int CFG_W   = 12;
	localparam int CMD_W   = 4;
	localparam int RES_W   = 16;
	localparam int TAG_W   = 3;
	localparam int SHIFT_W = RES_W + TAG_W;

	// ---------------------------------------------
	// configuration word
	// ---------------------------------------------
	localparam logic [CFG_W-1:0] CFG_RESET = 12'hfff;
	localparam int CFG_AUTO_CH   = 11;
	localparam int CFG_CLK_INT   = 10;
	localparam int CFG_TRIG_MAN  = 9;
	localparam int CFG_RATE_SLOW = 8;
	localparam int CFG_POL_LOW   = 7;
	localparam int CFG_FUNC_EOC  = 6;
	localparam int CFG_PIN_OUT   = 5;
	localparam int CFG_DOZE_OFF  = 4;
	localparam int CFG_LIGHT_OFF = 3;
	localparam int CFG_DEEP_OFF  = 2;
	localparam int CFG_TAG_EN    = 1;
	localparam int CFG_RUN       = 0;

	// ---------------------------------------------
	// command codes
	// ---------------------------------------------
	localparam logic [CMD_W-1:0] CMD_CH_MAX     = 4'h7;
	localparam logic [CMD_W-1:0] CMD_WAKE       = 4'hb;
	localparam logic [CMD_W-1:0] CMD_READ_CFG   = 4'hc;
	localparam logic [CMD_W-1:0] CMD_READ_DATA  = 4'hd;
	localparam logic [CMD_W-1:0] CMD_WRITE_CFG  = 4'he;
	localparam logic [CMD_W-1:0] CMD_DEFAULT    = 4'hf;

	// ---------------------------------------------
	// frame edges and timing
	// ---------------------------------------------
	localparam logic [4:0] EDGE_CMD  = 5'h04;
	localparam logic [4:0] EDGE_WORD = 5'h10;
	localparam int SAMPLE_CONVERSION_CLOCK = 3;
	localparam int PERIOD_FAST = 21;
	localparam int PERIOD_SLOW = 42;
	localparam logic [5:0] WAIT_FAST = 6'(SAMPLE_CONVERSION_CLOCK);
	localparam logic [5:0] WAIT_SLOW = 6'(SAMPLE_CONVERSION_CLOCK + PERIOD_SLOW - PERIOD_FAST);
	localparam int CLK_MHZ   = 100;
	localparam int QUIET_NS  = 20;
	localparam int QUIET_CYC = (QUIET_NS * CLK_MHZ + 999) / 1000;
	localparam int OSC_DIV   = 4;

	// ---------------------------------------------
	// trigger states
	// ---------------------------------------------
	typedef enum logic [2:0] {
		TRG_IDLE = 3'h1,
		TRG_CONV = 3'h2,
		TRG_WAIT = 3'h4
	} trig_state_e;

endpackage

// ---- pkg/pin_evt_if.sv ----
// synchronised pin levels and edges of the serial link
`timescale 1ns/1ps
interface pin_evt_if;
	logic sclk_fall;
	logic fs_fall;
	logic fs_rise;
	logic fs_low;
	logic sdi;
	logic convert_start_n_fall;
	logic ext_rst;
	logic chain_in;
	modport src (output sclk_fall, fs_fall, fs_rise, fs_low, sdi, convert_start_n_fall, ext_rst, chain_in);
	modport dst (input sclk_fall, fs_fall, fs_rise, fs_low, sdi, convert_start_n_fall, ext_rst, chain_in);
endinterface

// ---- rtl/link_sampler.sv ----
// two-stage synchronisers and edge detection for the link pins
`timescale 1ns/1ps
module link_sampler (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// raw pins: chain, reset_n, convert_start_n_n, sdi, fs_n, sclk
	input  wire logic [5:0] i_pins,
	// synchronised events
	pin_evt_if.src    evt
);
	localparam logic [5:0] IDLE_LVL = 6'h1b;

	logic [5:0] s1_reg;
	logic [5:0] s2_reg;
	logic [5:0] s3_reg;

	// per pin: two flops, then a delayed copy for edges
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_sync
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					s1_reg[gi] <= IDLE_LVL[gi];
					s2_reg[gi] <= IDLE_LVL[gi];
					s3_reg[gi] <= IDLE_LVL[gi];
				end else begin
					s1_reg[gi] <= i_pins[gi];
					s2_reg[gi] <= s1_reg[gi];
					s3_reg[gi] <= s2_reg[gi];
				end
			end
		end
	endgenerate

	// edges from second stage against delayed copy, levels from second stage
	assign evt.sclk_fall   = s3_reg[0] & ~s2_reg[0] & ~s2_reg[1];
	assign evt.fs_fall     = s3_reg[1] & ~s2_reg[1];
	assign evt.fs_rise     = ~s3_reg[1] & s2_reg[1];
	assign evt.fs_low      = ~s2_reg[1];
	assign evt.sdi         = s2_reg[2];
	assign evt.convert_start_n_fall = s3_reg[3] & ~s2_reg[3];
	assign evt.ext_rst     = ~s2_reg[4];
	assign evt.chain_in    = s2_reg[5];
endmodule

// ---- rtl/trigger_timer.sv ----
// conversion start sequencing in automatic and manual trigger modes
`timescale 1ns/1ps
module trigger_timer (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// controls
	input  wire logic i_conversion_clock_tick,
	input  wire logic i_auto,
	input  wire logic i_slow,
	input  wire logic i_convert_start_n_fall,
	input  wire logic i_conv_done,
	// results
	output logic      o_conv_start,
	output logic      o_sample_end,
	output logic      o_busy
);
	adc_cmd_pkg::trig_state_e state_reg;
	adc_cmd_pkg::trig_state_e state_next;
	logic [5:0] cnt_reg;
	logic [5:0] cnt_inc;
	logic [5:0] wait_len;
	logic       wait_tick;
	logic       start_now;
	logic       end_now;

	// start decisions
	assign wait_len  = i_slow ? adc_cmd_pkg::WAIT_SLOW : adc_cmd_pkg::WAIT_FAST;
	assign cnt_inc   = cnt_reg + 6'h01;
	assign wait_tick = (state_reg == adc_cmd_pkg::TRG_WAIT) & i_conversion_clock_tick & i_auto;
	assign start_now = (i_auto & (state_reg == adc_cmd_pkg::TRG_IDLE))
		| (wait_tick & (cnt_inc == wait_len))
		| (~i_auto & i_convert_start_n_fall & (state_reg != adc_cmd_pkg::TRG_CONV));
	assign end_now   = (wait_tick & (cnt_inc == adc_cmd_pkg::WAIT_FAST))
		| (~i_auto & i_convert_start_n_fall & (state_reg != adc_cmd_pkg::TRG_CONV));

	// next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			adc_cmd_pkg::TRG_IDLE: begin
				if (start_now) state_next = adc_cmd_pkg::TRG_CONV;
			end
			adc_cmd_pkg::TRG_CONV: begin
				if (i_conv_done) state_next = adc_cmd_pkg::TRG_WAIT;
			end
			adc_cmd_pkg::TRG_WAIT: begin
				if (start_now) state_next = adc_cmd_pkg::TRG_CONV;
			end
			default: state_next = adc_cmd_pkg::TRG_IDLE;
		endcase
	end

	// state, counter and pulses
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg    <= adc_cmd_pkg::TRG_IDLE;
			cnt_reg      <= 6'h00;
			o_conv_start <= 1'b0;
			o_sample_end <= 1'b0;
			o_busy       <= 1'b0;
		end else begin
			state_reg    <= state_next;
			cnt_reg      <= (state_reg != adc_cmd_pkg::TRG_WAIT) ? 6'h00 : (wait_tick ? cnt_inc : cnt_reg);
			o_conv_start <= start_now;
			o_sample_end <= end_now;
			o_busy       <= (state_next == adc_cmd_pkg::TRG_CONV);
		end
	end
endmodule

// ---- rtl/adc_serial_command_config.sv ----
// serial command decoder, configuration word and result output of the converter
`timescale 1ns/1ps
module adc_serial_command_config #(
	parameter int NUM_CH  = 8,
	parameter int CH_W    = 3,
	parameter int OSC_DIV = adc_cmd_pkg::OSC_DIV
) (
	// clock and reset
	input  wire logic I_CLOCK,
	input  wire logic I_SYS_RST,
	// serial link pins
	input  wire logic I_SCLK,
	input  wire logic I_FS_N,
	input  wire logic I_SDI,
	output logic      O_SDO,
	output logic      O_SDO_OE,
	// control pins
	input  wire logic I_CONVERT_START_N_N,
	input  wire logic I_RESET_N,
	// shared status pin
	input  wire logic I_STATUS_PIN,
	output logic      O_STATUS_PIN,
	output logic      O_STATUS_PIN_OE,
	// converter core
	input  wire logic                          I_CONV_DONE,
	input  wire logic [adc_cmd_pkg::RES_W-1:0] I_CONV_RESULT,
	output logic                               O_CONV_START,
	output logic                               O_SAMPLE_END,
	output logic                               O_CONVERSION_CLOCK_TICK,
	output logic [CH_W-1:0]                    O_CHANNEL,
	// power and chain
	output logic                               O_LIGHT_PD,
	output logic                               O_DEEP_PD,
	output logic                               O_DOZE,
	output logic                               O_CHAIN_DATA
);
	localparam int SW = adc_cmd_pkg::SHIFT_W;
	localparam int CW = adc_cmd_pkg::CFG_W;
	localparam int TW = adc_cmd_pkg::TAG_W;

	// ---------------------------------------------
	// declarations
	// ---------------------------------------------
	pin_evt_if evt ();
	logic                 soft_rst_reg;
	logic                 rst_int;
	logic [4:0]           cnt_reg;
	logic [4:0]           cnt_inc;
	logic [15:0]          shin_reg;
	logic [15:0]          shin_next;
	logic [3:0]           cmd_reg;
	logic [3:0]           cmd_now;
	logic                 cmd_edge;
	logic                 word_edge;
	logic                 is_chan;
	logic                 is_wake;
	logic                 is_default;
	logic                 is_write;
	logic                 is_rdcfg;
	logic                 wakes_doze;
	logic [CW-1:0]        cfg_reg;
	logic [CW-1:0]        cfg_next;
	logic [CW-1:0]        cfg_wr;
	logic                 soft_req;
	logic [CH_W-1:0]      ch_reg;
	logic [CH_W-1:0]      ch_next;
	logic [CH_W-1:0]      conv_ch_reg;
	logic [CH_W-1:0]      tag_reg;
	logic [15:0]          odr_reg;
	logic                 first_reg;
	logic [SW-1:0]        out_reg;
	logic [SW-1:0]        out_load;
	logic [SW-1:0]        out_next;
	logic                 sclk_div_reg;
	logic [7:0]           osc_cnt_reg;
	logic                 osc_tick;
	logic                 conversion_clock_tick;
	logic                 conv_start;
	logic                 sample_end;
	logic                 busy;
	logic                 irq_reg;
	logic                 irq_clear;
	logic                 pin_level;
	logic                 doze_en;
	logic [5:0]           raw_pins;

	// ---------------------------------------------
	// pin sampling and reset sources
	// ---------------------------------------------
	assign raw_pins = {I_STATUS_PIN, I_RESET_N, I_CONVERT_START_N_N, I_SDI, I_FS_N, I_SCLK};

	link_sampler u_sampler (
		.i_clk  (I_CLOCK),
		.i_rst  (I_SYS_RST),
		.i_pins (raw_pins),
		.evt    (evt)
	);

	// system, pin and software resets combined
	assign rst_int = I_SYS_RST | evt.ext_rst | soft_rst_reg;

	// ---------------------------------------------
	// frame counter and input shifting
	// ---------------------------------------------
	assign cnt_inc   = (cnt_reg == 5'h1f) ? cnt_reg : cnt_reg + 5'h01;
	assign shin_next = {shin_reg[14:0], evt.sdi};
	assign cmd_now   = shin_next[3:0];
	assign cmd_edge  = evt.sclk_fall & evt.fs_low & (cnt_inc == adc_cmd_pkg::EDGE_CMD);
	assign word_edge = evt.sclk_fall & evt.fs_low & (cnt_inc == adc_cmd_pkg::EDGE_WORD);

	// count falling edges inside a frame
	always_ff @(posedge I_CLOCK) begin
		if (rst_int | evt.fs_fall) begin
			cnt_reg  <= 5'h00;
			shin_reg <= 16'h0000;
		end else if (evt.sclk_fall & evt.fs_low) begin
			cnt_reg  <= cnt_inc;
			shin_reg <= shin_next;
		end
	end

	// ---------------------------------------------
	// command decode
	// ---------------------------------------------
	assign is_chan    = cmd_edge & (cmd_now <= adc_cmd_pkg::CMD_CH_MAX);
	assign is_wake    = cmd_edge & (cmd_now == adc_cmd_pkg::CMD_WAKE);
	assign is_default = cmd_edge & (cmd_now == adc_cmd_pkg::CMD_DEFAULT);
	assign is_rdcfg   = cmd_edge & (cmd_now == adc_cmd_pkg::CMD_READ_CFG);
	assign is_write   = word_edge & (cmd_reg == adc_cmd_pkg::CMD_WRITE_CFG);
	assign wakes_doze = is_chan | is_wake | is_default;
	assign cfg_wr     = shin_next[CW-1:0];
	assign soft_req   = is_write & ~cfg_wr[adc_cmd_pkg::CFG_RUN];

	// latch the command at the fourth edge
	always_ff @(posedge I_CLOCK) begin
		if (rst_int) begin
			cmd_reg <= adc_cmd_pkg::CMD_READ_DATA;
		end else if (cmd_edge) begin
			cmd_reg <= cmd_now;
		end
	end

	// ---------------------------------------------
	// configuration word
	// ---------------------------------------------
	// reserved codes fall through unchanged
	always_comb begin
		cfg_next = cfg_reg;
		if (is_default) begin
			cfg_next = adc_cmd_pkg::CFG_RESET;
		end else if (is_wake) begin
			cfg_next[adc_cmd_pkg::CFG_LIGHT_OFF] = 1'b1;
			cfg_next[adc_cmd_pkg::CFG_DEEP_OFF]  = 1'b1;
		end else if (is_write) begin
			cfg_next = soft_req ? adc_cmd_pkg::CFG_RESET : cfg_wr;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (rst_int) begin
			cfg_reg <= adc_cmd_pkg::CFG_RESET;
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	// software reset pulse, cleared by the next cycle
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			soft_rst_reg <= 1'b0;
		end else begin
			soft_rst_reg <= soft_req;
		end
	end

	// ---------------------------------------------
	// conversion clock and trigger
	// ---------------------------------------------
	assign osc_tick  = (osc_cnt_reg == 8'(OSC_DIV - 1));
	assign conversion_clock_tick = cfg_reg[adc_cmd_pkg::CFG_CLK_INT] ? osc_tick
		: (evt.sclk_fall & sclk_div_reg);

	// serial clock halving and oscillator divider
	always_ff @(posedge I_CLOCK) begin
		if (rst_int) begin
			sclk_div_reg <= 1'b0;
			osc_cnt_reg  <= 8'h00;
			O_CONVERSION_CLOCK_TICK  <= 1'b0;
		end else begin
			sclk_div_reg <= sclk_div_reg ^ evt.sclk_fall;
			osc_cnt_reg  <= osc_tick ? 8'h00 : osc_cnt_reg + 8'h01;
			O_CONVERSION_CLOCK_TICK  <= conversion_clock_tick;
		end
	end

	trigger_timer u_trigger (
		.i_clk         (I_CLOCK),
		.i_rst         (rst_int),
		.i_conversion_clock_tick   (conversion_clock_tick),
		.i_auto        (~cfg_reg[adc_cmd_pkg::CFG_TRIG_MAN]),
		.i_slow        (cfg_reg[adc_cmd_pkg::CFG_RATE_SLOW]),
		.i_convert_start_n_fall (evt.convert_start_n_fall),
		.i_conv_done   (I_CONV_DONE),
		.o_conv_start  (conv_start),
		.o_sample_end  (sample_end),
		.o_busy        (busy)
	);

	assign O_CONV_START = conv_start;
	assign O_SAMPLE_END = sample_end;

	// ---------------------------------------------
	// channel selection
	// ---------------------------------------------
	always_comb begin
		ch_next = ch_reg;
		if (cfg_reg[adc_cmd_pkg::CFG_AUTO_CH] & conv_start) begin
			ch_next = (ch_reg == CH_W'(NUM_CH - 1)) ? '0 : ch_reg + CH_W'(1);
		end else if (is_chan & ~cfg_reg[adc_cmd_pkg::CFG_AUTO_CH]) begin
			ch_next = cmd_now[CH_W-1:0];
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (rst_int) begin
			ch_reg      <= '0;
			conv_ch_reg <= '0;
		end else begin
			ch_reg      <= ch_next;
			conv_ch_reg <= conv_start ? ch_reg : conv_ch_reg;
		end
	end

	assign O_CHANNEL = ch_reg;

	// ---------------------------------------------
	// output data register and shifter
	// ---------------------------------------------
	// capture result and its channel at done
	always_ff @(posedge I_CLOCK) begin
		if (rst_int) begin
			odr_reg <= 16'h0000;
			tag_reg <= '0;
		end else if (I_CONV_DONE) begin
			odr_reg <= I_CONV_RESULT;
			tag_reg <= conv_ch_reg;
		end
	end

	// frame load: all ones after reset, else result and tag
	assign out_load = first_reg ? {SW{1'b1}}
		: {odr_reg, cfg_reg[adc_cmd_pkg::CFG_TAG_EN] ? TW'(tag_reg) : {TW{1'b0}}};

	always_comb begin
		out_next = out_reg;
		if (evt.fs_fall) begin
			out_next = out_load;
		end else if (is_rdcfg) begin
			out_next = {cfg_reg, 7'h00};
		end else if (evt.sclk_fall & evt.fs_low) begin
			out_next = {out_reg[SW-2:0], 1'b0};
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (rst_int) begin
			out_reg   <= {SW{1'b1}};
			first_reg <= 1'b1;
			O_SDO_OE  <= 1'b0;
		end else begin
			out_reg   <= out_next;
			first_reg <= first_reg & ~evt.fs_fall;
			O_SDO_OE  <= evt.fs_low & ~evt.fs_rise;
		end
	end

	assign O_SDO = out_reg[SW-1];

	// ---------------------------------------------
	// status pin and power controls
	// ---------------------------------------------
	assign irq_clear = cmd_edge & ~is_rdcfg;
	assign pin_level = cfg_reg[adc_cmd_pkg::CFG_FUNC_EOC] ? ~busy : irq_reg;
	assign doze_en   = ~cfg_reg[adc_cmd_pkg::CFG_DOZE_OFF]
		& (cfg_reg[adc_cmd_pkg::CFG_TRIG_MAN] | cfg_reg[adc_cmd_pkg::CFG_RATE_SLOW]);

	// ready flag: set beats clear
	always_ff @(posedge I_CLOCK) begin
		if (rst_int) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= I_CONV_DONE | (irq_reg & ~irq_clear);
		end
	end

	// registered pin and power outputs
	always_ff @(posedge I_CLOCK) begin
		if (rst_int) begin
			O_STATUS_PIN    <= 1'b0;
			O_STATUS_PIN_OE <= 1'b1;
			O_LIGHT_PD      <= 1'b0;
			O_DEEP_PD       <= 1'b0;
			O_DOZE          <= 1'b0;
			O_CHAIN_DATA    <= 1'b0;
		end else begin
			O_STATUS_PIN    <= pin_level ^ cfg_reg[adc_cmd_pkg::CFG_POL_LOW];
			O_STATUS_PIN_OE <= cfg_reg[adc_cmd_pkg::CFG_PIN_OUT];
			O_LIGHT_PD      <= ~cfg_reg[adc_cmd_pkg::CFG_LIGHT_OFF];
			O_DEEP_PD       <= ~cfg_reg[adc_cmd_pkg::CFG_DEEP_OFF];
			O_DOZE          <= doze_en & (I_CONV_DONE | (O_DOZE & ~conv_start & ~wakes_doze));
			O_CHAIN_DATA    <= ~cfg_reg[adc_cmd_pkg::CFG_PIN_OUT] & evt.chain_in;
		end
	end
endmodule

// ---- verif/adc_cmd_checker.sv ----
// assertion checker for the serial command and configuration block
`timescale 1ns/1ps
module adc_cmd_checker #(
	parameter int CH_W = 3
) (
	input wire logic            I_CLOCK,
	input wire logic            I_SYS_RST,
	input wire logic            I_FS_N,
	input wire logic            O_SDO_OE,
	input wire logic            O_STATUS_PIN_OE,
	input wire logic            O_CHAIN_DATA,
	input wire logic            O_CONV_START,
	input wire logic            O_SAMPLE_END,
	input wire logic            O_CONVERSION_CLOCK_TICK,
	input wire logic [CH_W-1:0] O_CHANNEL,
	input wire logic            O_LIGHT_PD,
	input wire logic            O_DEEP_PD
);
	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (I_SYS_RST);

	// frame select idle for a while, and a frame just closed
	sequence fs_idle;
		I_FS_N [*8];
	endsequence
	sequence fs_end;
		$rose(I_FS_N) ##1 I_FS_N;
	endsequence

	oe_idle_a: assert property (fs_idle |-> !O_SDO_OE)
		else $error("data output driven outside a frame");
	oe_release_a: assert property (fs_end |-> ##[0:6] !O_SDO_OE)
		else $error("data output not released after frame");
	reset_state_a: assert property ($fell(I_SYS_RST) |-> !O_SDO_OE && !O_LIGHT_PD && !O_DEEP_PD
		&& O_CHANNEL == '0 && O_STATUS_PIN_OE)
		else $error("outputs not at reset state");
	chain_gate_a: assert property (O_STATUS_PIN_OE |-> !O_CHAIN_DATA)
		else $error("chain data passed while pin is output");
	cfg_hold_a: assert property (fs_idle |-> $stable(O_LIGHT_PD) && $stable(O_DEEP_PD))
		else $error("power controls changed outside a frame");
	start_pulse_a: assert property (O_CONV_START |=> !O_CONV_START)
		else $error("conversion start longer than one cycle");
	end_pulse_a: assert property (O_SAMPLE_END |=> !O_SAMPLE_END)
		else $error("sample end longer than one cycle");
	tick_pulse_a: assert property (O_CONVERSION_CLOCK_TICK |=> !O_CONVERSION_CLOCK_TICK)
		else $error("conversion clock tick longer than one cycle");
endmodule

bind adc_serial_command_config adc_cmd_checker #(.CH_W(CH_W)) chk (
	.I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_FS_N(I_FS_N), .O_SDO_OE(O_SDO_OE),
	.O_STATUS_PIN_OE(O_STATUS_PIN_OE), .O_CHAIN_DATA(O_CHAIN_DATA),
	.O_CONV_START(O_CONV_START), .O_SAMPLE_END(O_SAMPLE_END), .O_CONVERSION_CLOCK_TICK(O_CONVERSION_CLOCK_TICK),
	.O_CHANNEL(O_CHANNEL), .O_LIGHT_PD(O_LIGHT_PD), .O_DEEP_PD(O_DEEP_PD)
);

// ---- verif/spi_host_model.sv ----
// serial master model that frames commands and collects returned bits
`timescale 1ns/1ps
module spi_host_model #(
	parameter int HALF = 6
) (
	input  wire logic i_clk,
	input  wire logic i_sdo,
	output logic      o_sclk,
	output logic      o_fs_n,
	output logic      o_sdi
);
	// clock idles high between frames
	initial begin
		o_sclk = 1'b1;
		o_fs_n = 1'b1;
		o_sdi  = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	// one frame of n clocks, bits taken from tx[23] down
	task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
		rx = 24'h00_0000;
		o_fs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			o_sdi = tx[23-i];
			tick(HALF);
			rx = {rx[22:0], i_sdo}; // taken just before the falling edge
			o_sclk = 1'b0;
			tick(HALF);
			o_sclk = 1'b1;
		end
		tick(HALF);
		o_fs_n = 1'b1;
		o_sdi = ~o_sdi; // idle data line shows no stale value
		tick(8);
	endtask
endmodule

// ---- verif/adc_serial_command_config_tb.sv ----
// self-checking testbench of the serial command and configuration block
`timescale 1ns/1ps
module adc_serial_command_config_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        convert_start_n_n = 1'b1;
	logic        rst_n = 1'b1;
	logic        chain = 1'b0;
	logic        done = 1'b0;
	logic [15:0] result = 16'h0000;
	logic        sclk;
	logic        fs_n;
	logic        sdi;
	logic        sdo;
	logic        sdo_oe;
	logic        sdo_w;
	logic        st_pin;
	logic        st_oe;
	logic        start;
	logic        tick_c;
	logic [2:0]  chan;
	logic        light_pd;
	logic        deep_pd;
	logic        doze;
	logic        chain_o;
	logic        samp;
	logic [23:0] rx;
	int          fails = 0;
	int          checked = 0;
	int          ticks = 0;

	always #5 clk = ~clk;
	// conversion clock ticks seen, sampled away from the launching edge
	always @(negedge clk) ticks += int'(tick_c);
	// released data line floats
	assign sdo_w = sdo_oe ? sdo : 1'bz;

	adc_serial_command_config dut (
		.I_CLOCK(clk), .I_SYS_RST(rst), .I_SCLK(sclk), .I_FS_N(fs_n), .I_SDI(sdi),
		.O_SDO(sdo), .O_SDO_OE(sdo_oe), .I_CONVERT_START_N_N(convert_start_n_n), .I_RESET_N(rst_n),
		.I_STATUS_PIN(chain), .O_STATUS_PIN(st_pin), .O_STATUS_PIN_OE(st_oe),
		.I_CONV_DONE(done), .I_CONV_RESULT(result), .O_CONV_START(start),
		.O_SAMPLE_END(samp), .O_CONVERSION_CLOCK_TICK(tick_c), .O_CHANNEL(chan),
		.O_LIGHT_PD(light_pd), .O_DEEP_PD(deep_pd), .O_DOZE(doze), .O_CHAIN_DATA(chain_o)
	);
	spi_host_model host (
		.i_clk(clk), .i_sdo(sdo_w), .o_sclk(sclk), .o_fs_n(fs_n), .o_sdi(sdi)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic frame(input logic [3:0] cmd, input logic [11:0] d, input int n);
		host.xfer({cmd, d, 8'h00}, n, rx);
	endtask

	// manual start, then the core hands back a result; no frame meanwhile
	task automatic convert(input logic [15:0] res);
		convert_start_n_n = 1'b0;
		for (int k = 0; k < 20 && start !== 1'b1; k++) tick(1);
		check("conv start", 24'(start), 24'h00_0001);
		check("sample end", 24'(samp), 24'h00_0001);
		convert_start_n_n = 1'b1;
		tick(2);
		check("eoc busy", 24'(st_pin), 24'h00_0001);
		result = res;
		done = 1'b1;
		tick(1);
		done = 1'b0;
		tick(3);
		check("eoc idle", 24'(st_pin), 24'h00_0000);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		check("reset outs", 24'({sdo_oe, st_oe, light_pd, deep_pd, chan}), 24'h00_0020);
		frame(4'hd, 12'h000, 24);
		check("first frame", rx, 24'hff_ffe0);
		$display("test reset done");
	endtask

	task automatic t_config();
		frame(4'he, 12'h6ff, 16);
		convert(16'ha5c3);
		frame(4'hc, 12'h000, 16);
		check("read cfg", rx, 24'h00_a6ff);
		frame(4'hd, 12'h000, 24);
		check("read data", rx, 24'ha5_c300);
		check("status oe", 24'(st_oe), 24'h00_0001);
		$display("test config done");
	endtask

	task automatic t_channel();
		for (int c = 0; c < 11; c++) begin
			frame(4'(c), 12'h000, 4);
			check("nibble out", rx, 24'h00_000a);
			check("channel", 24'(chan), 24'(c < 8 ? c : 7));
		end
		convert(16'h3c5a);
		frame(4'hd, 12'h000, 24);
		check("tagged data", rx, 24'h3c_5ae0);
		frame(4'hc, 12'h000, 16);
		check("cfg kept", rx, 24'h00_36ff);
		$display("test channel done");
	endtask

	task automatic t_power();
		frame(4'he, 12'h6f1, 16);
		check("power down", 24'({light_pd, deep_pd}), 24'h00_0003);
		frame(4'hd, 12'h000, 24);
		check("untagged", rx, 24'h3c_5a00);
		frame(4'hb, 12'h000, 4);
		check("wake", 24'({light_pd, deep_pd}), 24'h00_0000);
		frame(4'hc, 12'h000, 16);
		check("wake cfg", rx, 24'h00_36fd);
		$display("test power done");
	endtask

	// auto trigger: conversion clocks from done to next start
	task automatic auto_gap(input logic [11:0] cfg, input int n);
		int cnt;
		cnt = 0;
		frame(4'he, cfg, 16);
		tick(10);
		result = 16'h1234;
		done = 1'b1;
		tick(1);
		done = 1'b0;
		for (int k = 0; k < 600 && start !== 1'b1; k++) begin
			tick(1);
			cnt += int'(tick_c);
		end
		check("auto gap", 24'(cnt), 24'(n));
	endtask

	task automatic t_auto();
		auto_gap(12'h4ff, 3);
		auto_gap(12'h5ff, 24);
		$display("test auto done");
	endtask

	task automatic t_swreset();
		frame(4'he, 12'h6fe, 16);
		tick(4);
		check("sw reset chan", 24'(chan), 24'h00_0000);
		frame(4'hd, 12'h000, 24);
		check("after sw reset", rx, 24'hff_ffe0);
		frame(4'hc, 12'h000, 16);
		check("run bit back", 24'(rx[11:0]), 24'h00_0fff);
		$display("test swreset done");
	endtask

	task automatic t_default();
		frame(4'he, 12'h6f1, 16);
		frame(4'hf, 12'h000, 4);
		check("default pd", 24'({light_pd, deep_pd}), 24'h00_0000);
		frame(4'hc, 12'h000, 16);
		check("default cfg", 24'(rx[11:0]), 24'h00_0fff);
		convert(16'h0001);
		check("auto chan", 24'(chan), 24'h00_0001);
		frame(4'h5, 12'h000, 4);
		check("chan cmd ignored", 24'(chan), 24'h00_0001);
		$display("test default done");
	endtask

	// chain input, ready flag, doze, halved serial clock, reset pin
	task automatic t_pins();
		int n0;
		frame(4'he, 12'h20d, 16);
		check("pin as input", 24'({st_oe, st_pin, doze}), 24'h00_0000);
		chain = 1'b1;
		tick(4);
		check("chain in", 24'(chain_o), 24'h00_0001);
		chain = 1'b0;
		result = 16'h8421;
		done = 1'b1;
		tick(1);
		done = 1'b0;
		tick(3);
		check("int set", 24'({st_pin, doze}), 24'h00_0003);
		n0 = ticks;
		frame(4'hd, 12'h000, 16);
		check("int clear", 24'({st_pin, doze, chain_o}), 24'h00_0002);
		check("sclk half", 24'(ticks - n0), 24'h00_0008);
		check("int data", rx, 24'h00_8421);
		frame(4'hb, 12'h000, 4);
		check("doze wake", 24'(doze), 24'h00_0000);
		rst_n = 1'b0;
		tick(4);
		rst_n = 1'b1;
		tick(4);
		frame(4'hc, 12'h000, 16);
		check("pin reset", rx, 24'h00_ffff);
		check("pin reset oe", 24'(st_oe), 24'h00_0001);
		$display("test pins done");
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		tick(5);
		rst = 1'b0;
		tick(4);
		t_reset();
		t_config();
		t_channel();
		t_power();
		t_auto();
		t_swreset();
		t_default();
		t_pins();
		finish_test();
	end

	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		$display("watchdog expired");
		finish_test();
	end
endmodule
